// *** clk_rate_pkg.sv ***
// Constants, register map and decode helpers for the clock and rate block
package clk_rate_pkg;
  localparam int ADDR_W = 12; // APB byte address width
  localparam int DATA_W = 32; // APB data width
  localparam int REG_W = 16; // Register payload width
  localparam int RATE_W = 5; // Sample rate code width
  localparam int FREQ_W = 26; // Frequency in Hz, fits 49.152MHz
  localparam int IDX_W = 9; // Register index width
  localparam int DIV_W = 5; // Output divider code width
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RATE_TWO = 9'h103;
  localparam logic [IDX_W-1:0] IDX_RATE_THREE = 9'h104;
  localparam logic [IDX_W-1:0] IDX_RATE_ONE_RPT = 9'h10A;
  localparam logic [IDX_W-1:0] IDX_RATE_TWO_RPT = 9'h10B;
  localparam logic [IDX_W-1:0] IDX_RATE_THREE_RPT = 9'h10C;
  localparam logic [IDX_W-1:0] IDX_SD_CFG = 9'h112;
  localparam logic [IDX_W-1:0] IDX_SD_RATE_ONE = 9'h113;
  localparam logic [IDX_W-1:0] IDX_SD_RATE_TWO = 9'h114;
  localparam logic [IDX_W-1:0] IDX_SD_RATE_ONE_RPT = 9'h11B;
  localparam logic [IDX_W-1:0] IDX_SD_RATE_TWO_RPT = 9'h11C;
  localparam logic [IDX_W-1:0] IDX_BLOCK_STATUS = 9'h120;
  localparam logic [IDX_W-1:0] IDX_MAIN_OUT_CFG = 9'h149;
  localparam logic [IDX_W-1:0] IDX_SD_OUT_CFG = 9'h14A;
  // Reset values
  localparam logic [RATE_W-1:0] RATE_RESET = 5'h11;
  localparam logic [RATE_W-1:0] REPORT_RESET = 5'h00;
  localparam logic [2:0] SD_FREQ_RESET = 3'h3;
  localparam logic [3:0] SD_SRC_RESET = 4'h5;
  // Field positions
  localparam int FREQ_LSB = 8;
  localparam int FREQ_MSB = 10;
  localparam int SD_ON_BIT = 6;
  localparam int SRC_MSB = 3;
  localparam int OUT_ON_BIT = 15;
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 3;
  localparam int SEL_MSB = 2;
  localparam int STS_OFF_BIT = 0;
  localparam int STS_MAIN_FAST_BIT = 1;
  localparam int STS_SD_FAST_BIT = 2;
  // Second domain source codes
  localparam logic [3:0] SRC_MREF_ONE = 4'h0;
  localparam logic [3:0] SRC_MREF_TWO = 4'h1;
  localparam logic [3:0] SRC_LOOP_ONE = 4'h4;
  localparam logic [3:0] SRC_LOOP_TWO = 4'h5;
  localparam logic [3:0] SRC_BCLK_ONE = 4'h8;
  localparam logic [3:0] SRC_BCLK_TWO = 4'h9;
  localparam logic [3:0] SRC_BCLK_THREE = 4'hA;
  // Highest defined frequency code, and the 44.1k family prefix
  localparam logic [2:0] FREQ_CODE_MAX = 3'h3;
  localparam logic [1:0] FAMILY_44K = 2'h1;
  localparam int SHUTDOWN_CYCLES_DEF = 8; // Wind-down time of the second domain
  localparam logic [DIV_W-1:0] DIV_BYPASS_MAX = 5'h01;

  // Frequency in Hz of a frequency code; zero for reserved codes
  function automatic logic [FREQ_W-1:0] freq_hz(input logic [2:0] code, input logic fam);
    case (code)
      3'h0: freq_hz = fam ? 26'd5644800 : 26'd6144000;
      3'h1: freq_hz = fam ? 26'd11289600 : 26'd12288000;
      3'h2: freq_hz = fam ? 26'd22579200 : 26'd24576000;
      3'h3: freq_hz = fam ? 26'd45158400 : 26'd49152000;
      default: freq_hz = '0;
    endcase
  endfunction : freq_hz

  // True for the defined sample rate codes
  function automatic logic rate_valid(input logic [RATE_W-1:0] code);
    rate_valid = (code <= 5'h05) || (code >= 5'h09 && code <= 5'h0D) ||
                 (code >= 5'h10 && code <= 5'h13);
  endfunction : rate_valid
endpackage : clk_rate_pkg

// *** div_if.sv ***
// Carrier between the top and an output clock divider
interface div_if;
  logic on; // Output clock enable
  logic [clk_rate_pkg::DIV_W-1:0] div; // Divider code
  logic src; // Source clock level, sampled on MCLK
  logic out; // Divided clock level
  modport ctrl (output on, output div, output src, input out);
  modport gen (input on, input div, input src, output out);
endinterface : div_if

// *** clk_out_divider.sv ***
// Divides a sampled source clock by a programmable ratio
module clk_out_divider (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  div_if.gen d
);
  logic src_q; // Previous source level
  logic [clk_rate_pkg::DIV_W-1:0] cnt_q; // Source period counter
  logic [clk_rate_pkg::DIV_W-1:0] ratio; // Effective ratio
  logic [clk_rate_pkg::DIV_W-1:0] cnt_d;
  logic out_q;
  logic rise;

  // Codes 0 and 1 both mean divide by one
  always_comb begin
    ratio = (d.div <= clk_rate_pkg::DIV_BYPASS_MAX) ? 5'h01 : d.div;
    rise = d.src && !src_q;
    cnt_d = (cnt_q >= ratio - 5'h01) ? '0 : cnt_q + 5'h01;
  end

  // Edge history of the source
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      src_q <= 1'b0;
    end else if (CE) begin
      src_q <= d.src;
    end
  end

  // Counter and output; high for the first half, rounded up
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (CE) begin
      if (!d.on) begin
        cnt_q <= '0;
        out_q <= 1'b0;
      end else if (ratio == 5'h01) begin
        out_q <= d.src;
      end else if (rise) begin
        cnt_q <= cnt_d;
        // Six bits so that divide by 31 cannot wrap the half point to zero
        out_q <= {1'b0, cnt_d} < (({1'b0, ratio} + 6'h01) >> 1);
      end
    end
  end

  assign d.out = out_q;

  chk_div_off: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    !d.on |=> !d.out) else $error("Divided clock runs while disabled");
  chk_div_bypass: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (d.on && d.div == 5'h00) |=> (d.out == $past(d.src))) else
    $error("Divide by one does not follow the source");
endmodule : clk_out_divider

// *** clk_rate_ctrl.sv ***
// Clock configuration and sample rate registers behind an APB slave
// Functional notes
// - Main rate two and three selectors, reset 11h
// - Three read-only main rate reports, reset zero
// - Second domain frequency code, four defined values
// - 44.1k family rates pick the alternative frequencies
// - Second domain source select, seven inputs, reset 0101
// - Second domain rate one selector with rate coding
// - Second domain rate two selector, same coding
// - Two read-only second domain rate reports
// - Main output frequency code, not above main clock; a higher code is still accepted and only flagged in status bit 1
// - Main output uses 44.1k family frequencies too
//
// Local design decision: the APB interface to the registers.
module clk_rate_ctrl #(
  parameter int SHUTDOWN_CYCLES = clk_rate_pkg::SHUTDOWN_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [clk_rate_pkg::ADDR_W-1:0] PADDR,
  input wire logic [clk_rate_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [clk_rate_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MAIN_DOMAIN_CLOCK,
  input wire logic MAIN_DOMAIN_ON,
  input wire logic [2:0] MAIN_FREQ_CODE,
  input wire logic [clk_rate_pkg::RATE_W-1:0] MAIN_RATE_ONE,
  input wire logic MASTER_REF_ONE,
  input wire logic MASTER_REF_TWO,
  input wire logic LOCKED_LOOP_ONE,
  input wire logic LOCKED_LOOP_TWO,
  input wire logic IFACE_ONE_BITCLK,
  input wire logic IFACE_TWO_BITCLK,
  input wire logic IFACE_THREE_BITCLK,
  output logic SECOND_DOMAIN_CLOCK,
  output logic SECOND_DOMAIN_OFF_FLAG,
  output logic [clk_rate_pkg::FREQ_W-1:0] SECOND_DOMAIN_FREQ_HZ,
  output logic [clk_rate_pkg::FREQ_W-1:0] MAIN_CLOCK_OUT_FREQ_HZ,
  output logic MAIN_CLOCK_OUT,
  output logic SECOND_CLOCK_OUT
);
  localparam int OFF_BOUND = SHUTDOWN_CYCLES + 2; // Wait bound for the off flag
  localparam logic [7:0] SHUT_MAX = 8'(SHUTDOWN_CYCLES); // Counter end value

  // Bus response flops
  logic pready_q;
  logic pslverr_q;
  logic [clk_rate_pkg::DATA_W-1:0] prdata_q;
  // Writable fields
  logic [clk_rate_pkg::RATE_W-1:0] rate_two_q; // Main rate two
  logic [clk_rate_pkg::RATE_W-1:0] rate_three_q; // Main rate three
  logic [2:0] sd_freq_q; // Second domain frequency code
  logic sd_on_q; // Second domain clock on
  logic [3:0] sd_src_q; // Second domain source select
  logic [clk_rate_pkg::RATE_W-1:0] sd_rate_one_q;
  logic [clk_rate_pkg::RATE_W-1:0] sd_rate_two_q;
  logic mo_on_q; // Main clock output on
  logic [clk_rate_pkg::DIV_W-1:0] mo_div_q;
  logic [2:0] mo_sel_q; // Main clock output frequency code
  logic so_on_q; // Second clock output on
  logic [clk_rate_pkg::DIV_W-1:0] so_div_q;
  logic [2:0] so_sel_q;
  // Reports and derived state
  logic [clk_rate_pkg::RATE_W-1:0] rpt_one_q;
  logic [clk_rate_pkg::RATE_W-1:0] rpt_two_q;
  logic [clk_rate_pkg::RATE_W-1:0] rpt_three_q;
  logic [clk_rate_pkg::RATE_W-1:0] sd_rpt_one_q;
  logic [clk_rate_pkg::RATE_W-1:0] sd_rpt_two_q;
  logic [7:0] off_cnt_q; // Wind-down counter
  logic off_flag_q;
  logic sd_clk_q;
  logic [clk_rate_pkg::FREQ_W-1:0] sd_freq_hz_q;
  logic [clk_rate_pkg::FREQ_W-1:0] mo_freq_hz_q;
  logic mo_fast_q; // Main output code above main clock
  logic so_fast_q; // Second output code above second clock
  // Decode
  logic [clk_rate_pkg::IDX_W-1:0] idx;
  logic addr_ok; // Aligned and in range
  logic hit; // Index is mapped
  logic ro; // Index is read-only
  logic [clk_rate_pkg::REG_W-1:0] rd16;
  logic [clk_rate_pkg::REG_W-1:0] wimg; // Merged write image
  logic setup;
  logic wr;
  logic sd_fam;
  logic main_fam;
  logic sd_mux;

  assign idx = PADDR[10:2];
  assign addr_ok = (PADDR[1:0] == 2'h0) && !PADDR[11];
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE && pready_q && !pslverr_q;
  assign sd_fam = sd_rate_one_q[4:3] == clk_rate_pkg::FAMILY_44K;
  assign main_fam = MAIN_RATE_ONE[4:3] == clk_rate_pkg::FAMILY_44K;

  // Read image of the addressed register; reserved bits read zero
  always_comb begin
    rd16 = '0;
    hit = addr_ok;
    ro = 1'b0;
    case (idx)
      clk_rate_pkg::IDX_RATE_TWO: rd16[4:0] = rate_two_q;
      clk_rate_pkg::IDX_RATE_THREE: rd16[4:0] = rate_three_q;
      clk_rate_pkg::IDX_RATE_ONE_RPT: begin
        rd16[4:0] = rpt_one_q;
        ro = 1'b1;
      end
      clk_rate_pkg::IDX_RATE_TWO_RPT: begin
        rd16[4:0] = rpt_two_q;
        ro = 1'b1;
      end
      clk_rate_pkg::IDX_RATE_THREE_RPT: begin
        rd16[4:0] = rpt_three_q;
        ro = 1'b1;
      end
      clk_rate_pkg::IDX_SD_CFG: begin
        rd16[clk_rate_pkg::FREQ_MSB:clk_rate_pkg::FREQ_LSB] = sd_freq_q;
        rd16[clk_rate_pkg::SD_ON_BIT] = sd_on_q;
        rd16[clk_rate_pkg::SRC_MSB:0] = sd_src_q;
      end
      clk_rate_pkg::IDX_SD_RATE_ONE: rd16[4:0] = sd_rate_one_q;
      clk_rate_pkg::IDX_SD_RATE_TWO: rd16[4:0] = sd_rate_two_q;
      clk_rate_pkg::IDX_SD_RATE_ONE_RPT: begin
        rd16[4:0] = sd_rpt_one_q;
        ro = 1'b1;
      end
      clk_rate_pkg::IDX_SD_RATE_TWO_RPT: begin
        rd16[4:0] = sd_rpt_two_q;
        ro = 1'b1;
      end
      clk_rate_pkg::IDX_BLOCK_STATUS: begin
        rd16[clk_rate_pkg::STS_OFF_BIT] = off_flag_q;
        rd16[clk_rate_pkg::STS_MAIN_FAST_BIT] = mo_fast_q;
        rd16[clk_rate_pkg::STS_SD_FAST_BIT] = so_fast_q;
        ro = 1'b1;
      end
      clk_rate_pkg::IDX_MAIN_OUT_CFG: begin
        rd16[clk_rate_pkg::OUT_ON_BIT] = mo_on_q;
        rd16[clk_rate_pkg::DIV_MSB:clk_rate_pkg::DIV_LSB] = mo_div_q;
        rd16[clk_rate_pkg::SEL_MSB:0] = mo_sel_q;
      end
      clk_rate_pkg::IDX_SD_OUT_CFG: begin
        rd16[clk_rate_pkg::OUT_ON_BIT] = so_on_q;
        rd16[clk_rate_pkg::DIV_MSB:clk_rate_pkg::DIV_LSB] = so_div_q;
        rd16[clk_rate_pkg::SEL_MSB:0] = so_sel_q;
      end
      default: hit = 1'b0; // Unmapped
    endcase
    // Only the two low byte lanes carry register bits
    wimg = rd16;
    if (PSTRB[0]) begin
      wimg[7:0] = PWDATA[7:0];
    end
    if (PSTRB[1]) begin
      wimg[15:8] = PWDATA[15:8];
    end
  end

  // Response is formed in setup, so the access phase never waits
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (CE) begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !hit || (PWRITE && ro);
        prdata_q <= (hit && !PWRITE) ? {16'h0000, rd16} : '0;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Main domain rate selectors
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rate_two_q <= clk_rate_pkg::RATE_RESET;
      rate_three_q <= clk_rate_pkg::RATE_RESET;
    end else if (CE && wr) begin
      if (idx == clk_rate_pkg::IDX_RATE_TWO) begin
        rate_two_q <= wimg[4:0];
      end
      if (idx == clk_rate_pkg::IDX_RATE_THREE) begin
        rate_three_q <= wimg[4:0];
      end
    end
  end

  // Second domain configuration; the source is assumed stable while on
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sd_freq_q <= clk_rate_pkg::SD_FREQ_RESET;
      sd_on_q <= 1'b0;
      sd_src_q <= clk_rate_pkg::SD_SRC_RESET;
      sd_rate_one_q <= clk_rate_pkg::RATE_RESET;
      sd_rate_two_q <= clk_rate_pkg::RATE_RESET;
    end else if (CE && wr) begin
      if (idx == clk_rate_pkg::IDX_SD_CFG) begin
        sd_freq_q <= wimg[clk_rate_pkg::FREQ_MSB:clk_rate_pkg::FREQ_LSB];
        sd_on_q <= wimg[clk_rate_pkg::SD_ON_BIT];
        sd_src_q <= wimg[clk_rate_pkg::SRC_MSB:0];
      end
      if (idx == clk_rate_pkg::IDX_SD_RATE_ONE) begin
        sd_rate_one_q <= wimg[4:0];
      end
      if (idx == clk_rate_pkg::IDX_SD_RATE_TWO) begin
        sd_rate_two_q <= wimg[4:0];
      end
    end
  end

  // Output clock configuration
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mo_on_q <= 1'b0;
      mo_div_q <= '0;
      mo_sel_q <= '0;
      so_on_q <= 1'b0;
      so_div_q <= '0;
      so_sel_q <= '0;
    end else if (CE && wr) begin
      if (idx == clk_rate_pkg::IDX_MAIN_OUT_CFG) begin
        mo_on_q <= wimg[clk_rate_pkg::OUT_ON_BIT];
        mo_div_q <= wimg[clk_rate_pkg::DIV_MSB:clk_rate_pkg::DIV_LSB];
        mo_sel_q <= wimg[clk_rate_pkg::SEL_MSB:0];
      end
      if (idx == clk_rate_pkg::IDX_SD_OUT_CFG) begin
        so_on_q <= wimg[clk_rate_pkg::OUT_ON_BIT];
        so_div_q <= wimg[clk_rate_pkg::DIV_MSB:clk_rate_pkg::DIV_LSB];
        so_sel_q <= wimg[clk_rate_pkg::SEL_MSB:0];
      end
    end
  end

  // Reports show an active valid rate, else zero
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rpt_one_q <= clk_rate_pkg::REPORT_RESET;
      rpt_two_q <= clk_rate_pkg::REPORT_RESET;
      rpt_three_q <= clk_rate_pkg::REPORT_RESET;
      sd_rpt_one_q <= clk_rate_pkg::REPORT_RESET;
      sd_rpt_two_q <= clk_rate_pkg::REPORT_RESET;
    end else if (CE) begin
      rpt_one_q <= (MAIN_DOMAIN_ON && clk_rate_pkg::rate_valid(MAIN_RATE_ONE)) ?
                   MAIN_RATE_ONE : clk_rate_pkg::REPORT_RESET;
      rpt_two_q <= (MAIN_DOMAIN_ON && clk_rate_pkg::rate_valid(rate_two_q)) ?
                   rate_two_q : clk_rate_pkg::REPORT_RESET;
      rpt_three_q <= (MAIN_DOMAIN_ON && clk_rate_pkg::rate_valid(rate_three_q)) ?
                     rate_three_q : clk_rate_pkg::REPORT_RESET;
      sd_rpt_one_q <= (sd_on_q && clk_rate_pkg::rate_valid(sd_rate_one_q)) ?
                      sd_rate_one_q : clk_rate_pkg::REPORT_RESET;
      sd_rpt_two_q <= (sd_on_q && clk_rate_pkg::rate_valid(sd_rate_two_q)) ?
                      sd_rate_two_q : clk_rate_pkg::REPORT_RESET;
    end
  end

  // Off flag rises only after the wind-down, so software knows it may write
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      off_cnt_q <= SHUT_MAX;
      off_flag_q <= 1'b1;
    end else if (CE) begin
      if (sd_on_q) begin
        off_cnt_q <= '0;
        off_flag_q <= 1'b0;
      end else if (off_cnt_q < SHUT_MAX) begin
        off_cnt_q <= off_cnt_q + 8'h01;
        off_flag_q <= off_cnt_q == SHUT_MAX - 8'h01;
      end
    end
  end

  // Source mux; reserved codes give a still clock
  always_comb begin
    case (sd_src_q)
      clk_rate_pkg::SRC_MREF_ONE: sd_mux = MASTER_REF_ONE;
      clk_rate_pkg::SRC_MREF_TWO: sd_mux = MASTER_REF_TWO;
      clk_rate_pkg::SRC_LOOP_ONE: sd_mux = LOCKED_LOOP_ONE;
      clk_rate_pkg::SRC_LOOP_TWO: sd_mux = LOCKED_LOOP_TWO;
      clk_rate_pkg::SRC_BCLK_ONE: sd_mux = IFACE_ONE_BITCLK;
      clk_rate_pkg::SRC_BCLK_TWO: sd_mux = IFACE_TWO_BITCLK;
      clk_rate_pkg::SRC_BCLK_THREE: sd_mux = IFACE_THREE_BITCLK;
      default: sd_mux = 1'b0;
    endcase
  end

  // Gated second domain clock and frequency views
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sd_clk_q <= 1'b0;
      sd_freq_hz_q <= '0;
      mo_freq_hz_q <= '0;
      mo_fast_q <= 1'b0;
      so_fast_q <= 1'b0;
    end else if (CE) begin
      sd_clk_q <= sd_on_q && sd_mux;
      sd_freq_hz_q <= clk_rate_pkg::freq_hz(sd_freq_q, sd_fam);
      mo_freq_hz_q <= clk_rate_pkg::freq_hz(mo_sel_q, main_fam);
      // Flag only; output still runs so software can see what it asked for
      mo_fast_q <= (mo_sel_q > clk_rate_pkg::FREQ_CODE_MAX) ||
                   (mo_sel_q > MAIN_FREQ_CODE);
      so_fast_q <= (so_sel_q > clk_rate_pkg::FREQ_CODE_MAX) || (so_sel_q > sd_freq_q);
    end
  end

  div_if mo_if ();
  div_if so_if ();
  assign mo_if.on = mo_on_q;
  assign mo_if.div = mo_div_q;
  assign mo_if.src = MAIN_DOMAIN_CLOCK;
  assign so_if.on = so_on_q;
  assign so_if.div = so_div_q;
  assign so_if.src = sd_clk_q;

  // Main clock output divider
  clk_out_divider u_main_div (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .CE(CE),
    .d(mo_if.gen)
  );

  // Second clock output divider
  clk_out_divider u_second_div (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .CE(CE),
    .d(so_if.gen)
  );

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SECOND_DOMAIN_CLOCK = sd_clk_q;
  assign SECOND_DOMAIN_OFF_FLAG = off_flag_q;
  assign SECOND_DOMAIN_FREQ_HZ = sd_freq_hz_q;
  assign MAIN_CLOCK_OUT_FREQ_HZ = mo_freq_hz_q;
  assign MAIN_CLOCK_OUT = mo_if.out;
  assign SECOND_CLOCK_OUT = so_if.out;

  chk_rate_two_write: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (wr && idx == clk_rate_pkg::IDX_RATE_TWO && PSTRB[0]) |=> ##1
    (rpt_two_q == (($past(MAIN_DOMAIN_ON) && clk_rate_pkg::rate_valid($past(PWDATA[4:0], 2))) ?
    $past(PWDATA[4:0], 2) : 5'h00)))
    else $error("Rate two write not mirrored");
  chk_report_idle: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    !MAIN_DOMAIN_ON |=> (rpt_one_q == 5'h00 && rpt_three_q == 5'h00))
    else $error("Main report nonzero while domain off");
  chk_sd_family_freq: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (sd_freq_q == 3'h3 && sd_rate_one_q[4:3] == 2'h1) |=> sd_freq_hz_q == 26'd45158400)
    else $error("Second domain 44.1k frequency wrong");
  chk_sd_base_freq: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (sd_freq_q == 3'h0 && sd_rate_one_q[4:3] != 2'h1) |=> sd_freq_hz_q == 26'd6144000)
    else $error("Second domain base frequency wrong");
  chk_sd_gated: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (!sd_on_q || sd_src_q == 4'hB) |=> !SECOND_DOMAIN_CLOCK)
    else $error("Second domain clock runs while off or reserved");
  chk_off_flag_wait: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    $fell(sd_on_q) |-> !off_flag_q ##[1:OFF_BOUND] off_flag_q)
    else $error("Off flag early or missing");
  chk_sd_report_off: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    !sd_on_q |=> (sd_rpt_one_q == 5'h00 && sd_rpt_two_q == 5'h00))
    else $error("Second domain report nonzero while off");
  chk_main_too_fast: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (mo_sel_q > MAIN_FREQ_CODE) |=> mo_fast_q)
    else $error("Main output overspeed not flagged");
  chk_main_family: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (mo_sel_q == 3'h1 && MAIN_RATE_ONE[4:3] == 2'h1) |=> mo_freq_hz_q == 26'd11289600)
    else $error("Main output 44.1k frequency wrong");
  chk_sd_rate_reset: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(RST_N) |-> (sd_rate_one_q == 5'h11 && sd_rate_two_q == 5'h11))
    else $error("Second domain rate reset wrong");
  chk_ro_refused: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
    (setup && PWRITE && idx == clk_rate_pkg::IDX_RATE_ONE_RPT && addr_ok) |=> PSLVERR)
    else $error("Write to report not refused");
endmodule : clk_rate_ctrl

// *** tb.sv ***
// Self-checking bench for the clock and rate register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
  logic MCLK = 1'b0, RST_N = 1'b0; // Clock and reset driven by the bench
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, mon = 1'b0, mdc = 1'b0; // Bus and main domain
  logic [11:0] pa = 12'h000; // Byte address
  logic [31:0] pw = 32'h0, r, rs = 32'hBE39, sd = 32'hBE39; // Data and random states
  logic [6:0] refs = 7'h00; // Reference levels, random each cycle
  logic [4:0] mr1 = 5'h00; // Main rate one code
  logic [2:0] mfc = 3'h3; // Main clock frequency code
  logic pmdc = 1'b0; // Main clock level seen at the previous edge
  logic e, sdc, off, mco, sco, prdy, perr; // Design outputs
  logic [31:0] prd; // Read data
  logic [25:0] sfreq, mfreq; // Decoded frequencies
  int err_total = 0, tests_run = 0, cyc = 0;
  int idx[14] = '{'h103, 'h104, 'h10A, 'h10B, 'h10C, 'h112, 'h113, 'h114, 'h11B, 'h11C,
                  'h149, 'h14A, 'h120, 'h105};
  int rv[14] = '{'h11, 'h11, 0, 0, 0, 'h305, 'h11, 'h11, 0, 0, 0, 0, 1, 0};
  // Short wind-down keeps the run brief
  clk_rate_ctrl #(.SHUTDOWN_CYCLES(2)) u_clk_rate_ctrl (.MCLK(MCLK), .RST_N(RST_N),
    .CE(1'b1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pw),
    .PSTRB(4'hF), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .MAIN_DOMAIN_CLOCK(mdc),
    .MAIN_DOMAIN_ON(mon), .MAIN_FREQ_CODE(mfc), .MAIN_RATE_ONE(mr1),
    .MASTER_REF_ONE(refs[0]), .MASTER_REF_TWO(refs[1]), .LOCKED_LOOP_ONE(refs[2]),
    .LOCKED_LOOP_TWO(refs[3]), .IFACE_ONE_BITCLK(refs[4]), .IFACE_TWO_BITCLK(refs[5]),
    .IFACE_THREE_BITCLK(refs[6]), .SECOND_DOMAIN_CLOCK(sdc), .SECOND_DOMAIN_OFF_FLAG(off),
    .SECOND_DOMAIN_FREQ_HZ(sfreq), .MAIN_CLOCK_OUT_FREQ_HZ(mfreq), .MAIN_CLOCK_OUT(mco),
    .SECOND_CLOCK_OUT(sco));
  // Half period of 2.5 ns gives 200 MHz
  always #2.5 MCLK = ~MCLK;
  // Next state of the random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Expected frequency in Hz; zero for reserved codes
  function automatic logic [25:0] fhz(input logic [2:0] c, input logic f);
    if (c > 3'h3) return 26'h0;
    return (f ? 26'd5644800 : 26'd6144000) << c;
  endfunction : fhz
  // Defined rate codes
  function automatic logic rok(input logic [4:0] c);
    return c <= 5'h05 || (c >= 5'h09 && c <= 5'h0D) || (c >= 5'h10 && c <= 5'h13);
  endfunction : rok
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Random references, main clock level and hang guard
  always @(posedge MCLK) begin
    rs <= lfsr(rs);
    refs <= rs[6:0];
    mdc <= rs[9];
    pmdc <= mdc;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // One APB transfer; an idle cycle after it avoids double drives in one step
  task automatic apb(input logic w, input int i, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= 12'(i * 4);
    pw <= d;
    @(posedge MCLK);
    pen <= 1'b1;
    do @(posedge MCLK); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge MCLK);
  endtask : apb
  initial begin
    logic [4:0] v;
    logic p1, p2, p3, ex;
    int k;
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    // Reset values, plus one unmapped index
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, idx[i], 32'h0);
      `CHK(r, 32'(rv[i]))
      `CHK(e, i == 13)
    end
    apb(1'b1, 'h10A, 32'h1F); // Report is read-only
    `CHK(e, 1'b1)
    $display("reset and refusal test done");
    // Random selector codes, read back and main report mirror
    mon <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      sd = lfsr(sd);
      v = sd[4:0];
      mr1 <= v;
      apb(1'b1, idx[i % 2 + (i / 2 % 2) * 6], {16'hFFFF, 11'h0, v});
      apb(1'b0, idx[i % 2 + (i / 2 % 2) * 6], 32'h0);
      `CHK(r, {27'h0, v})
      apb(1'b0, 'h10A, 32'h0);
      `CHK(r, {27'h0, rok(v) ? v : 5'h00})
    end
    $display("selector test done");
    // Every frequency code in both rate families
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 2; f++) begin
        mr1 <= f ? 5'h0B : 5'h03;
        mfc <= f ? 3'h1 : 3'h3;
        apb(1'b1, 'h113, f ? 32'h0B : 32'h03);
        apb(1'b1, 'h112, 32'(c * 256 + 5));
        apb(1'b1, 'h149, 32'(c));
        @(posedge MCLK);
        `CHK(sfreq, fhz(3'(c), f[0]))
        `CHK(mfreq, fhz(3'(c), f[0]))
        apb(1'b0, 'h120, 32'h0);
        `CHK(r[1], c > (f ? 1 : 3))
      end
    end
    $display("frequency test done");
    // Enable on loop one, both outputs undivided, then wind down
    apb(1'b1, 'h112, 32'h0304);
    apb(1'b1, 'h112, 32'h0344);
    apb(1'b1, 'h149, 32'h8000);
    apb(1'b1, 'h14A, 32'h8000);
    apb(1'b0, 'h11B, 32'h0);
    `CHK(r, 32'h0B)
    for (int i = 0; i < 16; i++) begin
      p1 = refs[2];
      p2 = mdc;
      p3 = sdc;
      @(posedge MCLK);
      `CHK(sdc, p1)
      `CHK(mco, p2)
      `CHK(sco, p3)
      `CHK(off, 1'b0)
    end
    apb(1'b1, 'h112, 32'h0304);
    repeat (3) @(posedge MCLK);
    `CHK(off, 1'b1)
    `CHK(sdc, 1'b0)
    apb(1'b0, 'h120, 32'h0);
    `CHK(r, 32'h1)
    $display("clock gating test done");
    // Main output divided by 31: high for 16 of every 31 source periods
    apb(1'b1, 'h149, 32'h0);
    apb(1'b1, 'h149, 32'h80F8);
    k = 0;
    ex = 1'b0;
    for (int i = 0; i < 200; i++) begin
      if (mdc && !pmdc) begin
        k = (k == 30) ? 0 : k + 1;
        ex = k < 16;
      end
      @(posedge MCLK);
      `CHK(mco, ex)
    end
    $display("divider test done");
    finish_test();
  end
endmodule : tb
